// ===== plc_glitch_filter.sv
// receive glitch filter with bypass
`timescale 1ns/100ps
`default_nettype none
module plc_glitch_filter #(
  parameter int LEN = 52,
  parameter int CNT_W = 7
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic raw,
  output logic clean
);

  logic [CNT_W-1:0] cnt_q;
  logic stable_q;

  // ----------------------------------------
  // level must hold LEN cycles to pass
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q <= '0;
      stable_q <= 1'b0;
      clean <= 1'b0;
    end else begin
      if (raw == stable_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CNT_W'(LEN - 1)) begin
        cnt_q <= '0;
        stable_q <= raw;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
      clean <= enable ? stable_q : raw;
    end
  end

endmodule : plc_glitch_filter
`default_nettype wire

// ===== plc_pin_config.sv
// pin-function, start-trigger and line configuration registers
//
// ----------------------------------------
// Summary of operation
// - error select 1: shared error pin shows receive error flag
// - error pin mode ignores receive error interrupt mask
// - error select 0: shared error pin is an led driver
// - led1 bit 1 lights ready-pin led, 0 turns it off
// - led1 bit acts only while ready select is 0
// - ready select 1: shared ready pin shows data ready flag
// - ready pin mode ignores data ready interrupt mask
// - ready select 0: shared ready pin is an led driver
// - trigger register holds 4-bit write-only code, upper bits zero, resets zero
// - written code matching a channel code starts its timer and message
// - trigger writes accepted regardless of chip address
// - config bit 7 selects receiver threshold class
// - config bit 6 selects current source (1) or sink (0)
// - config bits 5:4 set line current level
// - config bit 3 selects npn or pnp, ignored in push-pull
// - config bit 2 selects push-pull (1) or open drain (0)
// - config bit 1 disables line driver, pin floats
// - config bit 0 enables receive glitch filter, else bypassed
// ----------------------------------------
`timescale 1ns/100ps
`default_nettype none
module plc_pin_config
  import plc_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [CHIP_ADDR_W-1:0] chip_addr,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic receive_error_flag_a,
  input wire logic receive_error_irq_mask_a,
  input wire logic receive_data_ready_flag_a,
  input wire logic data_ready_irq_mask_a,
  input wire logic [NCH*TRIG_CODE_W-1:0] channel_start_code_assign,
  input wire logic [NCH-1:0] cycle_timer_enable,
  output logic [NCH-1:0] start_cycle_timer,
  output logic [NCH-1:0] start_message,
  output logic error_or_led2_pin_a,
  output logic ready_or_led1_pin_a,
  input wire logic line_tx_a,
  input wire logic line_pin_a_in,
  output logic line_pin_a_out,
  output logic line_pin_a_oe_n,
  output logic line_rx_a,
  output plc_line_cfg_t line_cfg_a
);

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic logic code_match(input logic [TRIG_CODE_W-1:0] code,
                                      input logic [TRIG_CODE_W-1:0] assigned);
    code_match = code == assigned;
  endfunction : code_match

  plc_wr_t wr;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] led_q;
  logic [TRIG_CODE_W-1:0] trig_q;
  plc_line_cfg_t cfg_q;

  wire led_we = wr.valid && wr.addr == LED_CTRL_OFF;
  wire trig_we = wr.valid && wr.addr == TRIGGER_OFF;
  wire cfg_we = wr.valid && wr.addr == LINE_A_CFG_OFF;

  // trigger reads as zero, unmapped as zero
  assign rd_data = (rd_addr == LED_CTRL_OFF) ? led_q :
                   (rd_addr == LINE_A_CFG_OFF) ? cfg_q : 8'h00;

  // ----------------------------------------
  // serial port
  // ----------------------------------------
  plc_serial_port u_port (
    .mclk(mclk),
    .reset(reset),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .chip_addr(chip_addr),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n),
    .wr(wr)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      led_q <= LED_CTRL_RST;
      trig_q <= TRIGGER_RST;
      cfg_q <= LINE_A_CFG_RST;
    end else begin
      if (led_we) led_q <= wr.data;
      if (trig_we) trig_q <= wr.data[TRIG_CODE_W-1:0];
      if (cfg_we) cfg_q <= wr.data;
    end
  end

  assign line_cfg_a = cfg_q;

  // ----------------------------------------
  // trigger start pulses
  // ----------------------------------------
  wire [NCH-1:0] hit;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      assign hit[ch] = trig_we && code_match(wr.data[TRIG_CODE_W-1:0],
                       channel_start_code_assign[ch*TRIG_CODE_W +: TRIG_CODE_W]);
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      start_message <= '0;
      start_cycle_timer <= '0;
    end else begin
      start_message <= hit;
      start_cycle_timer <= hit & cycle_timer_enable;
    end
  end

  // ----------------------------------------
  // shared indication / led pins
  // ----------------------------------------
  wire err_pin_d = led_q[ERROR_SEL_BIT] ? receive_error_flag_a
                                        : led_q[LED2_ON_BIT];
  wire rdy_pin_d = led_q[READY_SEL_BIT] ? receive_data_ready_flag_a
                                        : led_q[LED1_ON_BIT];

  // ----------------------------------------
  // line driver
  // ----------------------------------------
  wire od_drive = cfg_q.low_side_polarity_a ? !line_tx_a : line_tx_a;
  wire drv_active = cfg_q.totem_pole_mode_a || od_drive;
  wire pin_val = cfg_q.totem_pole_mode_a ? line_tx_a : !cfg_q.low_side_polarity_a;

  always_ff @(posedge mclk) begin
    if (reset) begin
      error_or_led2_pin_a <= 1'b0;
      ready_or_led1_pin_a <= 1'b0;
      line_pin_a_out <= 1'b0;
      line_pin_a_oe_n <= 1'b1;
    end else begin
      error_or_led2_pin_a <= err_pin_d;
      ready_or_led1_pin_a <= rdy_pin_d;
      line_pin_a_out <= pin_val;
      line_pin_a_oe_n <= cfg_q.line_driver_off_a || !drv_active;
    end
  end

  plc_glitch_filter #(
    .LEN(GLITCH_CYCLES),
    .CNT_W(7)
  ) u_filter (
    .mclk(mclk),
    .reset(reset),
    .enable(cfg_q.glitch_filter_on_a),
    .raw(line_pin_a_in),
    .clean(line_rx_a)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_err_pin_flag: assert property (
    led_q[ERROR_SEL_BIT] |=> error_or_led2_pin_a == $past(receive_error_flag_a))
    else $error("error pin does not follow receive error flag");

  a_err_mask_free: assert property (
    led_q[ERROR_SEL_BIT] && receive_error_flag_a && !receive_error_irq_mask_a
    |=> error_or_led2_pin_a)
    else $error("error pin blocked by interrupt mask");

  a_err_led_mode: assert property (
    !led_q[ERROR_SEL_BIT] |=> error_or_led2_pin_a == $past(led_q[LED2_ON_BIT]))
    else $error("error pin not driven as led");

  a_led1_write_on: assert property (
    led_we && wr.data[1:0] == 2'b10 |=> ##1 ready_or_led1_pin_a)
    else $error("led1 did not turn on after write");

  a_led1_gated: assert property (
    led_q[READY_SEL_BIT] && led_q[LED1_ON_BIT] && !receive_data_ready_flag_a
    |=> !ready_or_led1_pin_a)
    else $error("led1 bit reached pin in ready mode");

  a_rdy_pin_flag: assert property (
    led_q[READY_SEL_BIT] |=> ready_or_led1_pin_a == $past(receive_data_ready_flag_a))
    else $error("ready pin does not follow data ready flag");

  a_rdy_mask_free: assert property (
    led_q[READY_SEL_BIT] && receive_data_ready_flag_a && !data_ready_irq_mask_a
    |=> ready_or_led1_pin_a)
    else $error("ready pin blocked by interrupt mask");

  a_rdy_led_mode: assert property (
    !led_q[READY_SEL_BIT] |=> ready_or_led1_pin_a == $past(led_q[LED1_ON_BIT]))
    else $error("ready pin not driven as led");

  a_trig_store: assert property (
    trig_we |=> trig_q == $past(wr.data[TRIG_CODE_W-1:0]))
    else $error("trigger code not stored");

  a_start_match: assert property (
    trig_we && code_match(wr.data[TRIG_CODE_W-1:0], channel_start_code_assign[3:0])
    |=> start_message[0] && start_cycle_timer[0] == $past(cycle_timer_enable[0]))
    else $error("matching trigger did not start channel");

  a_start_only_hit: assert property (
    !trig_we |=> start_message == '0)
    else $error("start pulse without trigger write");

  a_cfg_store: assert property (
    cfg_we |=> cfg_q == $past(wr.data))
    else $error("line config not stored");

  a_drv_off_float: assert property (
    cfg_q.line_driver_off_a |=> line_pin_a_oe_n)
    else $error("line driven while disabled");

  a_push_pull_drive: assert property (
    !cfg_q.line_driver_off_a && cfg_q.totem_pole_mode_a
    |=> !line_pin_a_oe_n && line_pin_a_out == $past(line_tx_a))
    else $error("push-pull driver not driving");

  a_filter_bypass: assert property (
    !cfg_q.glitch_filter_on_a |=> line_rx_a == $past(line_pin_a_in))
    else $error("filter not bypassed");

  a_led2_write_on: assert property (
    led_we && wr.data[3:2] == 2'b10 |=> ##1 error_or_led2_pin_a)
    else $error("led2 did not turn on after write");

  a_led2_write_off: assert property (
    led_we && wr.data[3:2] == 2'b00 |=> ##1 !error_or_led2_pin_a)
    else $error("led2 did not turn off after write");

  a_led1_write_off: assert property (
    led_we && wr.data[1:0] == 2'b00 |=> ##1 !ready_or_led1_pin_a)
    else $error("led1 did not turn off after write");

  a_led_reg_hold: assert property (
    !led_we |=> led_q == $past(led_q))
    else $error("led control changed without write");

  a_cfg_reg_hold: assert property (
    !cfg_we |=> cfg_q == $past(cfg_q))
    else $error("line config changed without write");

  a_trig_read_zero: assert property (
    rd_addr == TRIGGER_OFF |-> rd_data == 8'h00)
    else $error("trigger register not read as zero");

  a_start_ch1: assert property (
    trig_we && code_match(wr.data[TRIG_CODE_W-1:0],
                          channel_start_code_assign[2*TRIG_CODE_W-1:TRIG_CODE_W])
    |=> start_message[1] && start_cycle_timer[1] == $past(cycle_timer_enable[1]))
    else $error("matching trigger did not start second channel");

  a_start_miss: assert property (
    trig_we && !code_match(wr.data[TRIG_CODE_W-1:0], channel_start_code_assign[3:0])
    |=> !start_message[0])
    else $error("start pulse on code mismatch");

  a_timer_gated: assert property (
    trig_we && !cycle_timer_enable[0] |=> !start_cycle_timer[0])
    else $error("cycle timer started while disabled");

  a_start_one_cycle: assert property (
    start_message[0] |=> !start_message[0])
    else $error("start pulse longer than one cycle");

  a_npn_sinks: assert property (
    !cfg_q.line_driver_off_a && !cfg_q.totem_pole_mode_a && cfg_q.low_side_polarity_a
    && !line_tx_a |=> !line_pin_a_oe_n && !line_pin_a_out)
    else $error("npn driver not pulling low");

  a_pnp_sources: assert property (
    !cfg_q.line_driver_off_a && !cfg_q.totem_pole_mode_a && !cfg_q.low_side_polarity_a
    && line_tx_a |=> !line_pin_a_oe_n && line_pin_a_out)
    else $error("pnp driver not pulling high");

  a_open_drain_idle: assert property (
    !cfg_q.totem_pole_mode_a && cfg_q.low_side_polarity_a == line_tx_a
    |=> line_pin_a_oe_n)
    else $error("open drain driver active in its off state");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_trigger_hit: cover property (trig_we ##1 start_message[0]);
  c_err_mode_high: cover property (led_q[ERROR_SEL_BIT] && error_or_led2_pin_a);
  c_open_drain: cover property (!cfg_q.totem_pole_mode_a && !line_pin_a_oe_n);
  c_led1_lit: cover property (!led_q[READY_SEL_BIT] && ready_or_led1_pin_a);
  c_filter_pass: cover property (cfg_q.glitch_filter_on_a && $rose(line_rx_a));

endmodule : plc_pin_config
`default_nettype wire

// ===== plc_pin_config_test.sv
// self-checking bench for the pin-function, trigger and line config block
`timescale 1ns/100ps
`default_nettype none
module plc_pin_config_test;
  import plc_pkg::*;
  typedef struct {
    int kind;
    logic [7:0] exp;
  } plc_note_t;
  logic mclk, reset, sclk, cs_n, mosi, sdo_out, sdo_oe_n;
  logic [1:0] chip_addr, start_cycle_timer, start_message, cycle_timer_enable;
  logic receive_error_flag_a, receive_error_irq_mask_a, receive_data_ready_flag_a;
  logic data_ready_irq_mask_a, error_or_led2_pin_a, ready_or_led1_pin_a;
  logic [7:0] channel_start_code_assign, rd;
  logic line_tx_a, line_pin_a_in, line_pin_a_out, line_pin_a_oe_n, line_rx_a;
  plc_line_cfg_t line_cfg_a;
  int num_errors = 0;
  int checked = 0;
  plc_note_t q[$], tq[$];
  event probe;
  string names[6] = '{"read_data", "led_pins", "line_cfg", "line_drive", "line_rx",
    "start_pulses"};

  plc_pin_config #(.NCH(2)) uut (.mclk, .reset, .sclk, .cs_n, .mosi, .chip_addr,
    .sdo_out, .sdo_oe_n, .receive_error_flag_a, .receive_error_irq_mask_a,
    .receive_data_ready_flag_a, .data_ready_irq_mask_a, .channel_start_code_assign,
    .cycle_timer_enable, .start_cycle_timer, .start_message, .error_or_led2_pin_a,
    .ready_or_led1_pin_a, .line_tx_a, .line_pin_a_in, .line_pin_a_out,
    .line_pin_a_oe_n, .line_rx_a, .line_cfg_a);
  plc_spi_master master (.mclk, .sdo_out, .sdo_oe_n, .sclk, .cs_n, .mosi);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // compare, observe and closing
  // ----------------------------------------
  task automatic compare(input int kind, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", names[kind], exp, seen);
    end
  endtask : compare

  function automatic logic [7:0] observe(input int kind);
    case (kind)
      0: return rd;
      1: return {6'h00, error_or_led2_pin_a, ready_or_led1_pin_a};
      2: return line_cfg_a;
      3: return {6'h00, line_pin_a_out, line_pin_a_oe_n};
      default: return {7'h00, line_rx_a};
    endcase
  endfunction : observe

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic note(input int kind, input logic [7:0] exp);
    @(negedge mclk);
    q.push_back('{kind, exp});
    -> probe;
  endtask : note

  task automatic wr(input logic [1:0] ca, input logic [4:0] a, input logic [7:0] d);
    master.xfer({1'b0, ca, a, d}, rd);
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    master.xfer({1'b1, chip_addr, a, 8'h00}, rd);
    note(0, exp);
  endtask : rdchk

  task automatic hold(input logic lvl, input int n, input logic exp);
    @(posedge mclk);
    line_pin_a_in <= lvl;
    repeat (n) @(posedge mclk);
    note(4, {7'h00, exp});
  endtask : hold

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  initial forever begin
    @(probe);
    compare(q[0].kind, q[0].exp, observe(q[0].kind));
    void'(q.pop_front());
  end

  always @(negedge mclk) begin
    if (!reset && {start_message, start_cycle_timer} !== 4'h0) begin
      if (tq.size() == 0) compare(5, 8'h00, {4'h0, start_message, start_cycle_timer});
      else begin
        compare(5, tq[0].exp, {4'h0, start_message, start_cycle_timer});
        void'(tq.pop_front());
      end
    end
  end

  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v, a;
    logic [3:0] s;
    logic [1:0] en, m;
    reset = 1'b1;
    chip_addr = 2'h0;
    {receive_error_flag_a, receive_error_irq_mask_a} = 2'h0;
    {receive_data_ready_flag_a, data_ready_irq_mask_a} = 2'h0;
    channel_start_code_assign = 8'h00;
    cycle_timer_enable = 2'h0;
    line_tx_a = 1'b0;
    line_pin_a_in = 1'b0;
    void'($urandom(32'h0966));
    repeat (1) @(posedge mclk);
    note(1, 8'h00);
    note(2, 8'h00);
    note(3, 8'h01);
    @(posedge mclk);
    reset <= 1'b0;
    chip_addr <= 2'($urandom);
    rdchk(LED_CTRL_OFF, 8'h00);
    rdchk(TRIGGER_OFF, 8'h00);
    rdchk(LINE_A_CFG_OFF, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = {4'($urandom), i[3:0]};
      wr(chip_addr, LED_CTRL_OFF, v);
      rdchk(LED_CTRL_OFF, v);
      repeat (2) begin
        s = 4'($urandom);
        @(posedge mclk);
        {receive_error_flag_a, receive_error_irq_mask_a} <= s[3:2];
        {receive_data_ready_flag_a, data_ready_irq_mask_a} <= s[1:0];
        repeat (2) @(posedge mclk);
        note(1, {6'h00, v[2] ? s[3] : v[3], v[0] ? s[1] : v[1]});
      end
    end
    wr(chip_addr ^ 2'h1, LED_CTRL_OFF, ~v);
    rdchk(LED_CTRL_OFF, v);
    for (int i = 0; i < 32; i++) begin
      v = 8'($urandom);
      v[5:1] = i[4:0];
      wr(chip_addr, LINE_A_CFG_OFF, v);
      rdchk(LINE_A_CFG_OFF, v);
      note(2, v);
      for (int t = 0; t < 2; t++) begin
        @(posedge mclk);
        line_tx_a <= t[0];
        repeat (2) @(posedge mclk);
        note(3, {6'h00, v[2] ? t[0] : !v[3], v[1] | (!v[2] & (v[3] == t[0]))});
      end
    end
    wr(chip_addr, LINE_A_CFG_OFF, 8'h02);
    hold(1'b1, 2, 1'b1);
    hold(1'b0, 2, 1'b0);
    wr(chip_addr, LINE_A_CFG_OFF, 8'h03);
    hold(1'b1, 40, 1'b0);
    hold(1'b0, 5, 1'b0);
    hold(1'b1, 60, 1'b1);
    hold(1'b0, 60, 1'b0);
    for (int r = 0; r < 2; r++) begin
      master.half = 3 + 2 * r;
      a = 8'($urandom);
      if (r == 1) a[7:4] = a[3:0];
      @(posedge mclk);
      channel_start_code_assign <= a;
      for (int c = 0; c < 16; c++) begin
        en = 2'($urandom);
        m = {a[7:4] == c[3:0], a[3:0] == c[3:0]};
        @(posedge mclk);
        cycle_timer_enable <= en;
        if (m != 2'h0) tq.push_back('{5, {4'h0, m, m & en}});
        wr(2'($urandom), TRIGGER_OFF, {4'($urandom), c[3:0]});
      end
    end
    master.half = 3;
    compare(5, 8'h00, 8'(tq.size()));
    rdchk(TRIGGER_OFF, 8'h00);
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule : plc_pin_config_test
`default_nettype wire

// ===== plc_pkg.sv
// package: register map, field layout and timing for the pin-function block
package plc_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] LED_CTRL_OFF = 5'h0e;
  localparam logic [4:0] TRIGGER_OFF = 5'h0f;
  localparam logic [4:0] LINE_A_CFG_OFF = 5'h10;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] LED_CTRL_RST = 8'h00;
  localparam logic [3:0] TRIGGER_RST = 4'h0;
  localparam logic [7:0] LINE_A_CFG_RST = 8'h00;

  // ----------------------------------------
  // led_pin_control field positions and trigger code width
  // ----------------------------------------
  localparam int READY_SEL_BIT = 0;
  localparam int LED1_ON_BIT = 1;
  localparam int ERROR_SEL_BIT = 2;
  localparam int LED2_ON_BIT = 3;
  localparam int TRIG_CODE_W = 4;

  // ----------------------------------------
  // serial frame layout (header byte)
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int HDR_READ_BIT = 7;
  localparam int HDR_CHIP_MSB = 6;
  localparam int HDR_CHIP_LSB = 5;
  localparam int CHIP_ADDR_W = 2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int GLITCH_LEN_PS = 1300000;
  localparam int GLITCH_CYCLES = (GLITCH_LEN_PS / CLK_PERIOD_PS < 1) ? 1 :
                                 GLITCH_LEN_PS / CLK_PERIOD_PS;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic input_threshold_class_a;
    logic line_current_direction_a;
    logic [1:0] line_current_level_a;
    logic low_side_polarity_a;
    logic totem_pole_mode_a;
    logic line_driver_off_a;
    logic glitch_filter_on_a;
  } plc_line_cfg_t;

  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [7:0] data;
  } plc_wr_t;

endpackage : plc_pkg

// ===== plc_serial_port.sv
// serial register port: frame shifting, address check and read return
`timescale 1ns/100ps
`default_nettype none
module plc_serial_port
  import plc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [CHIP_ADDR_W-1:0] chip_addr,
  input wire logic [7:0] rd_data,
  output logic [4:0] rd_addr,
  output logic sdo_out,
  output logic sdo_oe_n,
  output plc_wr_t wr
);

  // ----------------------------------------
  // edge detect and frame decode
  // ----------------------------------------
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] hdr_q;
  wire rise = sclk && !sclk_q && !cs_n;
  wire fall = !sclk && sclk_q && !cs_n;
  wire [15:0] sh_next = {sh_q[14:0], mosi};
  wire hdr_done = rise && (cnt_q == 5'(HDR_BITS - 1));
  wire frame_done = rise && (cnt_q == 5'(FRAME_BITS - 1));
  wire chip_ok = hdr_q[HDR_CHIP_MSB:HDR_CHIP_LSB] == chip_addr;
  wire is_trig = hdr_q[4:0] == TRIGGER_OFF;
  wire do_write = frame_done && !hdr_q[HDR_READ_BIT] && (chip_ok || is_trig);

  assign rd_addr = sh_next[4:0];

  always_ff @(posedge mclk) begin
    sclk_q <= sclk;
    if (reset || cs_n) begin
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      hdr_q <= 8'h00;
    end else if (rise) begin
      cnt_q <= cnt_q + 5'h01;
      sh_q <= sh_next;
      if (hdr_done) hdr_q <= sh_next[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_q <= 8'h00;
      sdo_out <= 1'b0;
      sdo_oe_n <= 1'b1;
      wr <= '0;
    end else begin
      sdo_oe_n <= cs_n;
      if (hdr_done) begin
        tx_q <= (sh_next[HDR_READ_BIT]
                 && sh_next[HDR_CHIP_MSB:HDR_CHIP_LSB] == chip_addr) ? rd_data : 8'h00;
      end else if (fall && cnt_q >= 5'(HDR_BITS)) begin
        sdo_out <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
      wr.valid <= do_write;
      wr.addr <= hdr_q[4:0];
      wr.data <= sh_next[7:0];
    end
  end

endmodule : plc_serial_port
`default_nettype wire

// ===== plc_spi_master.sv
// serial bus master model standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module plc_spi_master (
  input wire logic mclk,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // mclk cycles per serial clock phase, raise for a slow host
  int half = 3;

  // ----------------------------------------
  // idle: serial clock still, data line toggling
  // ----------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  always @(posedge mclk) begin
    if (cs_n) mosi <= ~mosi;
  end

  // ----------------------------------------
  // one 16-bit frame, mode 0, msb first
  // ----------------------------------------
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge mclk);
      mosi <= f[i];
      repeat (half - 1) @(posedge mclk);
      sclk <= 1'b1;
      if (i < 8) rd[i] = sdo_oe_n ? 1'bx : sdo_out;
      repeat (half) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge mclk);
    cs_n <= 1'b1;
    @(posedge mclk);
  endtask : xfer
endmodule : plc_spi_master
`default_nettype wire
